// [event_flags.v]
// Sticky write-to-clear event flags, set by status changes or event pulses
`timescale 1ns/1ps
module event_flags #(
	parameter WIDTH = 4
) (
	input wire core_clk, // System clock
	input wire reset, // Synchronous reset, active high
	input wire arm, // Change detection enabled
	input wire [WIDTH-1:0] status_in, // Status levels watched for change
	input wire [WIDTH-1:0] pulse_in, // One-cycle event pulses
	input wire clear_we, // Clear strobe from register write
	input wire [WIDTH-1:0] clear_bits, // Ones clear the matching flags
	output wire [WIDTH-1:0] flags // Latched flags
);

genvar i;
generate
	for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
		// Per-bit registers so each has a single driving process
		reg prev_ff;
		reg flag_ff;
		wire set_evt;
		assign set_evt = (arm & (status_in[i] ^ prev_ff)) | pulse_in[i];
		always @(posedge core_clk) begin
			if (reset) begin
				prev_ff <= 1'b0;
				flag_ff <= 1'b0;
			end else begin
				prev_ff <= status_in[i];
				// Set wins over a clear in the same cycle
				if (set_evt) begin
					flag_ff <= 1'b1;
				end else if (clear_we & clear_bits[i]) begin
					flag_ff <= 1'b0;
				end
			end
		end
		assign flags[i] = flag_ff;
	end
endgenerate

endmodule

// [level_sync.v]
// Two-flop synchroniser for a vector of independent status levels
`timescale 1ns/1ps
module level_sync #(
	parameter WIDTH = 4
) (
	input wire core_clk, // System clock
	input wire reset, // Synchronous reset, active high
	input wire [WIDTH-1:0] async_in, // Levels from outside the clock domain
	output wire [WIDTH-1:0] sync_out // Synchronised levels
);

reg [WIDTH-1:0] meta_ff;
reg [WIDTH-1:0] sync_ff;

// First stage is read only by the second stage
always @(posedge core_clk) begin
	if (reset) begin
		meta_ff <= {WIDTH{1'b0}};
		sync_ff <= {WIDTH{1'b0}};
	end else begin
		meta_ff <= async_in;
		sync_ff <= meta_ff;
	end
end

assign sync_out = sync_ff;

endmodule

// [rail_charger_irq_defines.vh]
// Offsets, field positions, reset values and sizes of the charger and rail interrupt flag block
`ifndef RAIL_CHARGER_IRQ_DEFINES_VH
`define RAIL_CHARGER_IRQ_DEFINES_VH

// Register offsets on the serial register bus
`define CHG_IRQ_FLAGS_ADDR 8'h04
`define CHG_IRQ_MASK_ADDR 8'h05
`define RAIL_IRQ_FLAGS_ADDR 8'h06
`define RAIL_IRQ_MASK_ADDR 8'h07

// Reset values
`define CHG_IRQ_FLAGS_RST 8'h00
`define CHG_IRQ_MASK_RST 8'h7F
`define RAIL_IRQ_FLAGS_RST 8'h00
`define RAIL_IRQ_MASK_RST 8'hFF

// Implemented flag widths
`define CHG_FLAG_BITS 6
`define RAIL_FLAG_BITS 4

// Charger group field positions
`define CHG_GOOD_BIT 0
`define CHG_BATTERY_BIT 1
`define CHG_BATT_DETECT_BIT 2
`define CHG_PREQUAL_TMO_BIT 3
`define CHG_FAST_TMO_BIT 4
`define CHG_INPUT_ILIM_BIT 5

// Rail group field positions
`define RAIL_SYSTEM_LDO_BIT 0
`define RAIL_ALWAYS_ON_LDO_BIT 1
`define RAIL_SYSTEM_BUCK_BIT 2
`define RAIL_CORE_BUCK_BIT 3

// Synchroniser depth and cycles until change detection is armed after reset
`define SYNC_STAGES 2
`define ARM_DELAY 3

`endif

// [rail_charger_irq_flags.v]
// Charger and output rail second-tier interrupt flags, masks and summary request
`timescale 1ns/1ps
`include "rail_charger_irq_defines.vh"
module rail_charger_irq_flags #(
	parameter CHG_BITS = `CHG_FLAG_BITS,
	parameter RAIL_BITS = `RAIL_FLAG_BITS
) (
	input wire core_clk, // System clock, 200 MHz
	input wire reset, // Synchronous reset, active high
	input wire [7:0] reg_addr, // Register offset
	input wire reg_wr, // Write strobe, one cycle
	input wire [7:0] reg_wdata, // Write data
	input wire reg_rd, // Read strobe, one cycle
	output wire [7:0] reg_rdata, // Read data, held until next read
	output wire reg_rvalid, // Read data valid pulse
	input wire charger_good, // Charger good level from analog
	input wire battery_good, // Battery voltage good level from analog
	input wire battery_present, // Battery detection level from analog
	input wire prequal_timeout, // Pre-qual timer expiry pulse, core clock
	input wire fast_charge_timeout, // Fast charge timer expiry pulse, core clock
	input wire input_current_limit, // Input current limit pulse, core clock
	input wire core_buck_output_good_raw, // Core buck comparator level
	input wire system_buck_output_good_raw, // System buck comparator level
	input wire always_on_ldo_output_good_raw, // Always-on LDO comparator level
	input wire system_ldo_output_good_raw, // System LDO comparator level
	input wire power_good_compare_enable, // Comparator enable, core clock
	output wire core_buck_output_good, // Gated core buck good status
	output wire system_buck_output_good, // Gated system buck good status
	output wire always_on_ldo_output_good, // Gated always-on LDO good status
	output wire system_ldo_output_good, // Gated system LDO good status
	output wire charger_irq_pending, // Unmasked charger flag pending
	output wire rail_irq_pending, // Unmasked rail flag pending
	output wire irq_request // Summary interrupt request
);

localparam CHG_LEVELS = 3;

wire [CHG_LEVELS-1:0] chg_sync;
wire [RAIL_BITS-1:0] rail_sync;
wire [RAIL_BITS-1:0] rail_raw;
wire [RAIL_BITS-1:0] rail_good;
wire [CHG_BITS-1:0] chg_status;
wire [CHG_BITS-1:0] chg_pulse;
wire [CHG_BITS-1:0] chg_flags;
wire [RAIL_BITS-1:0] rail_flags;
wire chg_flags_clear;
wire rail_flags_clear;
wire chg_mask_we;
wire rail_mask_we;
wire arm;

reg [7:0] chg_mask_ff;
reg [7:0] rail_mask_ff;
reg [`ARM_DELAY-1:0] arm_ff;
reg [7:0] rdata_ff;
reg [7:0] nxt_rdata;
reg rvalid_ff;
reg [RAIL_BITS-1:0] rail_good_ff;
reg chg_pend_ff;
reg rail_pend_ff;
reg irq_ff;

// Analog levels cross into the core clock before any logic reads them
level_sync #(
	.WIDTH(CHG_LEVELS)
) u_chg_sync (
	.core_clk(core_clk),
	.reset(reset),
	.async_in({battery_present, battery_good, charger_good}),
	.sync_out(chg_sync)
);

assign rail_raw[`RAIL_CORE_BUCK_BIT] = core_buck_output_good_raw;
assign rail_raw[`RAIL_SYSTEM_BUCK_BIT] = system_buck_output_good_raw;
assign rail_raw[`RAIL_ALWAYS_ON_LDO_BIT] = always_on_ldo_output_good_raw;
assign rail_raw[`RAIL_SYSTEM_LDO_BIT] = system_ldo_output_good_raw;

level_sync #(
	.WIDTH(RAIL_BITS)
) u_rail_sync (
	.core_clk(core_clk),
	.reset(reset),
	.async_in(rail_raw),
	.sync_out(rail_sync)
);

// Ignore changes until the reference value is settled after reset
always @(posedge core_clk) begin
	if (reset) begin
		arm_ff <= {`ARM_DELAY{1'b0}};
	end else begin
		arm_ff <= {arm_ff[`ARM_DELAY-2:0], 1'b1};
	end
end

assign arm = arm_ff[`ARM_DELAY-1];

assign rail_good = rail_sync & {RAIL_BITS{power_good_compare_enable}};

assign chg_status = {3'b000, chg_sync};
assign chg_pulse = {input_current_limit, fast_charge_timeout, prequal_timeout, 3'b000};

// Register decode
assign chg_flags_clear = reg_wr & (reg_addr == `CHG_IRQ_FLAGS_ADDR);
assign chg_mask_we = reg_wr & (reg_addr == `CHG_IRQ_MASK_ADDR);
assign rail_flags_clear = reg_wr & (reg_addr == `RAIL_IRQ_FLAGS_ADDR);
assign rail_mask_we = reg_wr & (reg_addr == `RAIL_IRQ_MASK_ADDR);

// Write one clears a charger flag
event_flags #(
	.WIDTH(CHG_BITS)
) u_chg_flags (
	.core_clk(core_clk),
	.reset(reset),
	.arm(arm),
	.status_in(chg_status),
	.pulse_in(chg_pulse),
	.clear_we(chg_flags_clear),
	.clear_bits(reg_wdata[CHG_BITS-1:0]),
	.flags(chg_flags)
);

event_flags #(
	.WIDTH(RAIL_BITS)
) u_rail_flags (
	.core_clk(core_clk),
	.reset(reset),
	.arm(arm),
	.status_in(rail_good),
	.pulse_in({RAIL_BITS{1'b0}}),
	.clear_we(rail_flags_clear),
	.clear_bits(reg_wdata[RAIL_BITS-1:0]),
	.flags(rail_flags)
);

always @(posedge core_clk) begin
	if (reset) begin
		chg_mask_ff <= `CHG_IRQ_MASK_RST;
	end else if (chg_mask_we) begin
		chg_mask_ff <= reg_wdata;
	end
end

always @(posedge core_clk) begin
	if (reset) begin
		rail_mask_ff <= `RAIL_IRQ_MASK_RST;
	end else if (rail_mask_we) begin
		rail_mask_ff <= reg_wdata;
	end
end

// Read mux, reserved flag bits read zero
always @* begin
	nxt_rdata = 8'h00;
	if (reg_addr == `CHG_IRQ_FLAGS_ADDR) begin
		nxt_rdata = {2'b00, chg_flags};
	end else if (reg_addr == `CHG_IRQ_MASK_ADDR) begin
		nxt_rdata = chg_mask_ff;
	end else if (reg_addr == `RAIL_IRQ_FLAGS_ADDR) begin
		nxt_rdata = {4'h0, rail_flags};
	end else if (reg_addr == `RAIL_IRQ_MASK_ADDR) begin
		nxt_rdata = rail_mask_ff;
	end
end

// Read data holds between reads so a slow serial shifter can pick it up
always @(posedge core_clk) begin
	if (reset) begin
		rdata_ff <= 8'h00;
		rvalid_ff <= 1'b0;
	end else begin
		rvalid_ff <= reg_rd;
		if (reg_rd) begin
			rdata_ff <= nxt_rdata;
		end
	end
end

// Masked flags latch but do not request
always @(posedge core_clk) begin
	if (reset) begin
		chg_pend_ff <= 1'b0;
		rail_pend_ff <= 1'b0;
		irq_ff <= 1'b0;
		rail_good_ff <= {RAIL_BITS{1'b0}};
	end else begin
		chg_pend_ff <= |(chg_flags & ~chg_mask_ff[CHG_BITS-1:0]);
		rail_pend_ff <= |(rail_flags & ~rail_mask_ff[RAIL_BITS-1:0]);
		irq_ff <= (|(chg_flags & ~chg_mask_ff[CHG_BITS-1:0])) | (|(rail_flags & ~rail_mask_ff[RAIL_BITS-1:0]));
		rail_good_ff <= rail_good;
	end
end

assign reg_rdata = rdata_ff;
assign reg_rvalid = rvalid_ff;
assign charger_irq_pending = chg_pend_ff;
assign rail_irq_pending = rail_pend_ff;
assign irq_request = irq_ff;
assign core_buck_output_good = rail_good_ff[`RAIL_CORE_BUCK_BIT];
assign system_buck_output_good = rail_good_ff[`RAIL_SYSTEM_BUCK_BIT];
assign always_on_ldo_output_good = rail_good_ff[`RAIL_ALWAYS_ON_LDO_BIT];
assign system_ldo_output_good = rail_good_ff[`RAIL_SYSTEM_LDO_BIT];

endmodule

// [rail_charger_irq_flags_chk.sv]
// Port-level property checks for the charger and rail interrupt flag block
`timescale 1ns/1ps
module rail_charger_irq_flags_chk (
	input wire core_clk, // Clock
	input wire reset, // Sync reset
	input wire [7:0] reg_addr, // Offset
	input wire reg_rd, // Read strobe
	input wire [7:0] reg_rdata, // Read data
	input wire reg_rvalid, // Read valid
	input wire power_good_compare_enable, // Comparator enable
	input wire core_buck_output_good, // Gated status
	input wire system_ldo_output_good, // Gated status
	input wire charger_irq_pending, // Charger pending
	input wire rail_irq_pending, // Rail pending
	input wire irq_request // Summary request
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	chk_summary_is_or: assert property (irq_request == (charger_irq_pending | rail_irq_pending))
		else $error("summary request differs from pendings");
	chk_gate_forces_low: assert property (!power_good_compare_enable |=> !core_buck_output_good && !system_ldo_output_good)
		else $error("gated status high while comparators off");
	chk_quiet_after_reset: assert property ($fell(reset) |-> !irq_request && !reg_rvalid)
		else $error("output active right after reset");
	chk_rail_reserved_zero: assert property (reg_rd && reg_addr == 8'h06 |=> reg_rvalid && reg_rdata[7:4] == 4'h0)
		else $error("rail flag reserved bits not zero");
	chk_chg_reserved_zero: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rvalid && reg_rdata[7:6] == 2'h0)
		else $error("charger flag reserved bits not zero");
	chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("read valid without a read");
	chk_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
		else $error("read data moved without a read");
	chk_ldo_rise_enable: assert property ($rose(system_ldo_output_good) |-> $past(power_good_compare_enable))
		else $error("ldo status rose while comparators off");
	chk_buck_rise_enable: assert property ($rose(core_buck_output_good) |-> $past(power_good_compare_enable))
		else $error("buck status rose while comparators off");
	cover property (irq_request);
	cover property ($fell(core_buck_output_good));
	cover property (reg_rvalid && reg_rdata != 8'h00);
endmodule
bind rail_charger_irq_flags rail_charger_irq_flags_chk chk_i (.core_clk, .reset, .reg_addr, .reg_rd, .reg_rdata,
	.reg_rvalid, .power_good_compare_enable, .core_buck_output_good, .system_ldo_output_good,
	.charger_irq_pending, .rail_irq_pending, .irq_request);

// [rail_host_model.sv]
// Host side register bus model for the interrupt flag block
`timescale 1ns/1ps
module rail_host_model (
	input wire core_clk, // Clock
	output reg [7:0] reg_addr, // Offset
	output reg reg_wr, // Write strobe
	output reg [7:0] reg_wdata, // Write data
	output reg reg_rd, // Read strobe
	input wire [7:0] reg_rdata, // Read data
	input wire reg_rvalid // Read valid
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// ones clear flags, zeros leave them
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		// Released lines must not look valid
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
	endtask
endmodule

// [tb.sv]
// Self-checking bench for the charger and rail interrupt flag block
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module tb;
	typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
	logic reg_wr, reg_rd, reg_rvalid;
	logic chg_good = 1'b0;
	logic pg_en = 1'b1;
	logic fct = 1'b0;
	logic [3:0] rail_raw = 4'hF;
	wire [3:0] rail_good;
	wire chg_pend, rail_pend, irq_req;
	int err_count = 0;
	int tests_run = 0;
	int i;
	row_t rows [0:8] = '{'{0, 8'h04, 8'h00, 8'h00}, '{0, 8'h05, 8'h00, 8'h7F}, '{0, 8'h06, 8'h00, 8'h00},
		'{0, 8'h07, 8'h00, 8'hFF}, '{1, 8'h05, 8'hAA, 8'hAA}, '{1, 8'h07, 8'h5A, 8'h5A},
		'{1, 8'h08, 8'hFF, 8'h00}, '{1, 8'h06, 8'hFF, 8'h00}, '{1, 8'h05, 8'hFF, 8'hFF}};
	initial forever #2.5 core_clk = ~core_clk;
	rail_host_model host (.core_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid);
	rail_charger_irq_flags dut (.core_clk, .reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
		.reg_rvalid, .charger_good(chg_good), .battery_good(1'b1), .battery_present(1'b1),
		.prequal_timeout(1'b0), .fast_charge_timeout(fct), .input_current_limit(1'b0),
		.core_buck_output_good_raw(rail_raw[3]), .system_buck_output_good_raw(rail_raw[2]),
		.always_on_ldo_output_good_raw(rail_raw[1]), .system_ldo_output_good_raw(rail_raw[0]),
		.power_good_compare_enable(pg_en), .core_buck_output_good(rail_good[3]),
		.system_buck_output_good(rail_good[2]), .always_on_ldo_output_good(rail_good[1]),
		.system_ldo_output_good(rail_good[0]), .charger_irq_pending(chg_pend),
		.rail_irq_pending(rail_pend), .irq_request(irq_req));
	task report_and_stop;
		$display("tests %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task rchk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, rd_val);
		`CHK(rd_val, e)
	endtask
	task settle;
		repeat (5) @(negedge core_clk);
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		reset = 1'b0;
		// Let change detection arm first
		settle;
		for (i = 0; i < 9; i++) begin
			if (rows[i].wr)
				host.wr(rows[i].a, rows[i].d);
			rchk(rows[i].a, rows[i].e);
		end
		$display("register table done");
		for (i = 0; i < 4; i++) begin
			@(negedge core_clk);
			rail_raw[i] = ~rail_raw[i];
			settle;
			rchk(8'h06, 8'h01 << i);
			host.wr(8'h06, 8'h00);
			rchk(8'h06, 8'h01 << i);
			host.wr(8'h06, 8'h01 << i);
			rchk(8'h06, 8'h00);
		end
		`CHK(rail_good, 4'h0)
		$display("rail edges done");
		@(negedge core_clk);
		chg_good = 1'b1;
		settle;
		rchk(8'h04, 8'h01);
		`CHK(irq_req, 1'b0)
		host.wr(8'h05, 8'hFE);
		repeat (2) @(negedge core_clk);
		`CHK(chg_pend, 1'b1)
		`CHK(irq_req, 1'b1)
		host.wr(8'h04, 8'h01);
		repeat (2) @(negedge core_clk);
		`CHK(irq_req, 1'b0)
		rchk(8'h04, 8'h00);
		$display("charger flag done");
		@(negedge core_clk);
		fct = 1'b1;
		@(negedge core_clk);
		fct = 1'b0;
		rchk(8'h04, 8'h10);
		`CHK(irq_req, 1'b0)
		host.wr(8'h05, 8'hEF);
		repeat (2) @(negedge core_clk);
		`CHK(chg_pend, 1'b1)
		// Pulse and clear land on the same edge: the set must win
		fork
			host.wr(8'h04, 8'h10);
			begin
				@(negedge core_clk);
				fct = 1'b1;
				@(negedge core_clk);
				fct = 1'b0;
			end
		join
		rchk(8'h04, 8'h10);
		host.wr(8'h04, 8'h10);
		repeat (2) @(negedge core_clk);
		`CHK(chg_pend, 1'b0)
		$display("charger pulse done");
		@(negedge core_clk);
		rail_raw = 4'hF;
		settle;
		`CHK(rail_good, 4'hF)
		host.wr(8'h06, 8'h0F);
		@(negedge core_clk);
		pg_en = 1'b0;
		settle;
		`CHK(rail_good, 4'h0)
		rchk(8'h06, 8'h0F);
		host.wr(8'h07, 8'hF0);
		repeat (2) @(negedge core_clk);
		`CHK(rail_pend, 1'b1)
		`CHK(irq_req, 1'b1)
		$display("comparator gate done");
		@(negedge core_clk);
		reset = 1'b1;
		repeat (2) @(negedge core_clk);
		reset = 1'b0;
		`CHK(irq_req, 1'b0)
		rchk(8'h05, 8'h7F);
		rchk(8'h07, 8'hFF);
		rchk(8'h06, 8'h00);
		rchk(8'h04, 8'h00);
		`CHK(rail_pend, 1'b0)
		$display("mid-run reset done");
		report_and_stop;
	end
	initial begin
		#20000;
		err_count++;
		report_and_stop;
	end
endmodule
